// ==== hdl/lsp_consts.svh ====
`ifndef LSP_CONSTS_SVH
`define LSP_CONSTS_SVH
// Channel count and code widths
`define LSP_NUM_CH 16
`define LSP_DUTY_W 12
`define LSP_TRIM_W 6
// Latch widths: 16 x 12 and 16 x 6
`define LSP_DUTY_BITS 192
`define LSP_TRIM_BITS 96
// Counter limits and zero codes
`define LSP_CNT_ZERO 12'h000
`define LSP_CNT_MAX 12'hFFF
`define LSP_CNT_ONE 12'h001
`define LSP_DUTY_ZERO 12'h000
`define LSP_TRIM_ZERO 6'h00
`define LSP_TRIM_FULL 6'h3F
`endif

// ==== hdl/lsp_pkg.sv ====
`include "lsp_consts.svh"
package lsp_pkg;
    // Per-channel codes as carried between stages
    typedef logic [`LSP_DUTY_W-1:0] lsp_duty_t;
    typedef logic [`LSP_TRIM_W-1:0] lsp_trim_t;
    typedef lsp_duty_t [`LSP_NUM_CH-1:0] lsp_duty_arr_t;
    typedef lsp_trim_t [`LSP_NUM_CH-1:0] lsp_trim_arr_t;
    // Latch-side input bundle
    typedef struct packed {
        lsp_duty_arr_t duty;
        lsp_trim_arr_t trim;
    } lsp_codes_t;
    // Top-level state
    typedef struct packed {
        lsp_duty_arr_t duty;
        lsp_trim_arr_t trim;
        logic [`LSP_NUM_CH-1:0] on;
        lsp_trim_arr_t level;
        logic cnt_clk_q;
        logic strobe_q;
    } lsp_top_st_t;
    // Counter state
    typedef struct packed {
        logic [`LSP_DUTY_W-1:0] cnt;
        logic started;
    } lsp_cnt_st_t;
endpackage

// ==== hdl/lsp_gs_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lsp_consts.svh"
module lsp_gs_counter
    import lsp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control
    input wire logic blank,
    input wire logic count_edge,
    // Count out
    output logic [`LSP_DUTY_W-1:0] count,
    output logic count_step
);
    lsp_cnt_st_t st_r;
    lsp_cnt_st_t st_nxt;

    // ========================================
    // Grayscale counter
    // Started marks the first edge after blank; count then reads period index.
    always_comb begin
        st_nxt = st_r;
        if (blank) begin
            st_nxt.cnt = `LSP_CNT_ZERO;
            st_nxt.started = 1'b0;
        end else if (count_edge) begin
            if (!st_r.started) begin
                st_nxt.started = 1'b1;
                st_nxt.cnt = `LSP_CNT_ONE;
            end else if (st_r.cnt != `LSP_CNT_MAX) begin
                st_nxt.cnt = st_r.cnt + `LSP_CNT_ONE;
            end // Hold at top, no wrap
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count = st_nxt.cnt;
    assign count_step = !blank && count_edge;

    // ========================================
    // Checks
    property p_blank_zero;
        @(posedge clk_sys) disable iff (rst)
        blank |=> (st_r.cnt == `LSP_CNT_ZERO);
    endproperty
    a_blank_zero: assert property (p_blank_zero)
        else $error("counter not held at zero under blank");

    property p_count_inc;
        @(posedge clk_sys) disable iff (rst)
        (!blank && count_edge && st_r.started && st_r.cnt != `LSP_CNT_MAX)
            |=> (st_r.cnt == $past(st_r.cnt) + `LSP_CNT_ONE);
    endproperty
    a_count_inc: assert property (p_count_inc)
        else $error("counter did not step by one");

    property p_count_hold;
        @(posedge clk_sys) disable iff (rst)
        (!blank && st_r.cnt == `LSP_CNT_MAX) |=> (st_r.cnt == `LSP_CNT_MAX);
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("counter wrapped past top");

    property p_count_still;
        @(posedge clk_sys) disable iff (rst)
        (!blank && !count_edge) |=> $stable(st_r.cnt);
    endproperty
    a_count_still: assert property (p_count_still)
        else $error("counter moved without count edge");
endmodule
`default_nettype wire

// ==== hdl/lsp_top.sv ====
// Notes on behaviour
// - Per-channel current set in 64 steps.
// - Current is full scale times code over 63.
// - Trim latch has no guaranteed power-on value.
// - One 12-bit counter on count clock edges.
// - Blank clears and holds counter at zero.
// - After blank falls, count up per edge.
// - Nonzero channels start at first edge.
// - On while counter not above duty code.
// - Off at edge where counter exceeds duty.
// - Duty one gives exactly one period on.
// - Duty zero never turns on.
// - Once off, stays off until next blank; here a strobe that raises duty turns it back on.
// - Blank forces all sixteen outputs off.
// - Duty latch 192 bits, 12 per channel.
// - Trim latch 96 bits, 6 per channel.
// - Latch strobe rising edge updates codes immediately.
`timescale 1ns/1ps
`default_nettype none
`include "lsp_consts.svh"
module lsp_top
    import lsp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Display controller
    input wire logic output_blank,
    input wire logic pwm_count_clock,
    input wire logic latch_strobe,
    // Shift register contents
    input wire logic [`LSP_DUTY_BITS-1:0] duty_shift,
    input wire logic [`LSP_TRIM_BITS-1:0] trim_shift,
    // Sink stage
    output logic [`LSP_NUM_CH-1:0] sink_on,
    output logic [`LSP_TRIM_BITS-1:0] sink_level
);
    lsp_top_st_t st_r;
    lsp_top_st_t st_nxt;
    lsp_codes_t codes_in;
    lsp_duty_arr_t duty_eff;
    lsp_trim_arr_t trim_eff;
    logic strobe_rise;
    logic count_rise;
    logic [`LSP_DUTY_W-1:0] count;
    logic count_step;
    logic [`LSP_NUM_CH-1:0] on_nxt;

    // ========================================
    // Edge detection on controller pins
    assign codes_in.duty = lsp_duty_arr_t'(duty_shift);
    assign codes_in.trim = lsp_trim_arr_t'(trim_shift);
    assign strobe_rise = latch_strobe && !st_r.strobe_q;
    assign count_rise = pwm_count_clock && !st_r.cnt_clk_q;
    // Fresh codes are used in the same cycle they are latched
    assign duty_eff = strobe_rise ? codes_in.duty : st_r.duty;
    assign trim_eff = strobe_rise ? codes_in.trim : st_r.trim;

    lsp_gs_counter u_cnt (
        .clk_sys(clk_sys),
        .rst(rst),
        .blank(output_blank),
        .count_edge(count_rise),
        .count(count),
        .count_step(count_step)
    );

    // ========================================
    // Per-channel compare
    // Counter value after this edge is the period index (1 on first edge).
    // Once above duty the counter never drops while blank is low, so the
    // channel stays off; duty changes mid-period may glitch, as on silicon.
    genvar g;
    generate
        for (g = 0; g < `LSP_NUM_CH; g++) begin : g_ch
            always_comb begin
                if (output_blank) begin
                    on_nxt[g] = 1'b0;
                end else if (count == `LSP_CNT_ZERO) begin
                    on_nxt[g] = 1'b0;
                end else begin
                    on_nxt[g] = (count <= duty_eff[g]);
                end
            end
        end
    endgenerate

    // ========================================
    // Next state
    // Trim passes through unscaled, gated to zero when the channel is off; the analog stage scales by code/63.
    always_comb begin
        st_nxt = st_r;
        st_nxt.cnt_clk_q = pwm_count_clock;
        st_nxt.strobe_q = latch_strobe;
        st_nxt.duty = duty_eff;
        st_nxt.trim = trim_eff;
        st_nxt.on = on_nxt;
        for (int i = 0; i < `LSP_NUM_CH; i++) begin
            st_nxt.level[i] = on_nxt[i] ? trim_eff[i] : `LSP_TRIM_ZERO;
        end
    end

    // Reset clears control and the duty and trim latches alike to zero;
    // because the part guarantees no default, zero is just a safe value.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sink_on = st_r.on;
    assign sink_level = st_r.level;

    // ========================================
    // Checks
    property p_blank_off;
        @(posedge clk_sys) disable iff (rst)
        output_blank |=> (sink_on == '0 && sink_level == '0);
    endproperty
    a_blank_off: assert property (p_blank_off)
        else $error("outputs on during blank");

    // Count of one only follows the first accepted edge of a period
    property p_first_edge_on;
        @(posedge clk_sys) disable iff (rst)
        (count_step && count == `LSP_CNT_ONE
            && duty_eff[1] != `LSP_DUTY_ZERO) |=> sink_on[1];
    endproperty
    a_first_edge_on: assert property (p_first_edge_on)
        else $error("channel 1 did not start at first edge");

    property p_zero_never;
        @(posedge clk_sys) disable iff (rst)
        (st_r.duty[0] == `LSP_DUTY_ZERO && !strobe_rise) |=> !sink_on[0];
    endproperty
    a_zero_never: assert property (p_zero_never)
        else $error("zero duty channel turned on");

    property p_off_above;
        @(posedge clk_sys) disable iff (rst)
        (!output_blank && count > duty_eff[1]) |=> !sink_on[1];
    endproperty
    a_off_above: assert property (p_off_above)
        else $error("channel 1 on above duty");

    property p_on_below;
        @(posedge clk_sys) disable iff (rst)
        (!output_blank && count != `LSP_CNT_ZERO && count <= duty_eff[1])
            |=> sink_on[1];
    endproperty
    a_on_below: assert property (p_on_below)
        else $error("channel 1 off within duty");

    property p_stay_off;
        @(posedge clk_sys) disable iff (rst)
        (sink_on[2] && !output_blank && !strobe_rise ##1 !sink_on[2]
            && !output_blank && !strobe_rise) |=> !sink_on[2];
    endproperty
    a_stay_off: assert property (p_stay_off)
        else $error("channel 2 came back on in period");

    property p_level_gate;
        @(posedge clk_sys) disable iff (rst)
        1'b1 |=> (sink_level[`LSP_TRIM_W-1:0]
            == (sink_on[0] ? st_r.trim[0] : `LSP_TRIM_ZERO));
    endproperty
    a_level_gate: assert property (p_level_gate)
        else $error("level word not trim gated by on");

    property p_latch_now;
        @(posedge clk_sys) disable iff (rst)
        strobe_rise |=> (st_r.duty == $past(codes_in.duty));
    endproperty
    a_latch_now: assert property (p_latch_now)
        else $error("duty latch not updated on strobe");
endmodule
`default_nettype wire

// ==== tb/lsp_ctl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Display controller: blank and count clock
module lsp_ctl_model (
    // Clock
    input wire logic clk_sys,
    // Controls toward the block
    output logic output_blank,
    output logic pwm_count_clock
);
    // Blank high from power-on so nothing lights before codes load
    initial begin
        output_blank = 1'b1;
        pwm_count_clock = 1'b0;
    end
    // One count edge per two system cycles, the closest legal spacing
    task automatic count(input int n);
        repeat (n) begin
            @(posedge clk_sys) pwm_count_clock <= 1'b1;
            @(posedge clk_sys) pwm_count_clock <= 1'b0;
        end
        @(posedge clk_sys);
        #1;
    endtask
    // Blank level, settled one edge later
    task automatic set_blank(input logic v);
        @(posedge clk_sys) output_blank <= v;
        @(posedge clk_sys);
        #1;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench top
module tb_top;
    import lsp_pkg::*;
    logic clk_sys;
    logic rst;
    logic latch_strobe;
    logic output_blank;
    logic pwm_count_clock;
    logic [15:0] sink_on;
    logic [95:0] sink_level;
    lsp_duty_arr_t duty_v;
    lsp_trim_arr_t trim_v;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    int k = 0;
    // 100 MHz
    always #5 clk_sys = ~clk_sys;
    lsp_ctl_model u_lsp_ctl_model (.clk_sys(clk_sys), .output_blank(output_blank),
        .pwm_count_clock(pwm_count_clock));
    lsp_top u_lsp_top (.clk_sys(clk_sys), .rst(rst), .output_blank(output_blank),
        .pwm_count_clock(pwm_count_clock), .latch_strobe(latch_strobe),
        .duty_shift(duty_v), .trim_shift(trim_v), .sink_on(sink_on),
        .sink_level(sink_level));
    // Hang guard, well above the hold-at-top run
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Expected outputs after k count edges; the counter stops at the top
    task automatic expect_k();
        logic [15:0] on;
        lsp_trim_arr_t lvl;
        int kk;
        kk = (k > 4095) ? 4095 : k;
        for (int ch = 0; ch < 16; ch++) begin
            on[ch] = (kk >= 1) && (kk <= int'(duty_v[ch]));
            lvl[ch] = on[ch] ? trim_v[ch] : 6'h00;
        end
        check("sink_on", 96'(sink_on), 96'(on));
        check("sink_level", sink_level, 96'(lvl));
    endtask
    task automatic strobe();
        @(posedge clk_sys) latch_strobe <= 1'b1;
        @(posedge clk_sys) latch_strobe <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    // Codes load under blank; count edges there change nothing
    task automatic t_load_blank();
        @(posedge clk_sys);
        for (int ch = 0; ch < 16; ch++) begin
            duty_v[ch] <= (ch == 3) ? 12'hFFF : 12'(ch);
            trim_v[ch] <= (ch == 4) ? 6'h00 : 6'(ch * 4 + 3);
        end
        strobe();
        u_lsp_ctl_model.count(3);
        check("sink_on blanked", 96'(sink_on), 96'h0);
        check("sink_level blanked", sink_level, 96'h0);
    endtask
    // The first 17 edges of a period, edge by edge
    task automatic t_period();
        u_lsp_ctl_model.set_blank(1'b0);
        k = 0;
        expect_k();
        for (int i = 0; i < 17; i++) begin
            u_lsp_ctl_model.count(1);
            k++;
            expect_k();
        end
    endtask
    // Run past the top count: full duty stays on, short ones stay off
    task automatic t_hold_max();
        u_lsp_ctl_model.count(4095 - k);
        k = 4095;
        expect_k();
        u_lsp_ctl_model.count(5);
        k = 4100;
        expect_k();
        u_lsp_ctl_model.set_blank(1'b1);
        check("sink_on after blank", 96'(sink_on), 96'h0);
        check("sink_level after blank", sink_level, 96'h0);
    endtask
    // New period, then a code change mid-period applies at once
    task automatic t_mid_strobe();
        u_lsp_ctl_model.set_blank(1'b0);
        u_lsp_ctl_model.count(5);
        k = 5;
        expect_k();
        @(posedge clk_sys);
        duty_v[0] <= 12'h00A;
        duty_v[5] <= 12'h002;
        strobe();
        expect_k();
    endtask
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        latch_strobe = 1'b0;
        duty_v = '0;
        trim_v = '0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check("sink_on reset", 96'(sink_on), 96'h0);
        t_load_blank();
        t_period();
        t_hold_max();
        t_mid_strobe();
        end_of_test();
    end
endmodule
`default_nettype wire
